// >>> src/qdr_b2_pkg.sv
// Shared constants and types for the burst-of-two DDR static memory link.
// Assumes both ends are built from the same organisation setting.
package qdr_b2_pkg;

	// Organisation: 1 selects 36-bit words, 0 selects 18-bit words.
	localparam bit WIDE_ORG = 1'b1;
	localparam int DATA_W = WIDE_ORG ? 36 : 18;
	localparam int BYTE_W = 9;
	localparam int BYTES = DATA_W / BYTE_W;
	// One address names a burst of two words.
	localparam int ADDR_W = WIDE_ORG ? 20 : 21;
	localparam int BURST_LEN = 2;
	localparam int BEAT_W = 1;
	localparam int MEM_WORDS = BURST_LEN << ADDR_W;

	typedef logic [DATA_W-1:0] word_t;
	typedef logic [BYTES-1:0] mask_t;
	typedef logic [ADDR_W-1:0] addr_t;
	typedef logic [1:0] phase_t;

	// Beat selectors within a burst.
	localparam logic [BEAT_W-1:0] BEAT_FIRST = 1'h0;
	localparam logic [BEAT_W-1:0] BEAT_SECOND = 1'h1;
	localparam mask_t MASK_NONE = {BYTES{1'b1}};

	// Timing of the controller clock and the link clock it makes.
	localparam int CLK_PERIOD_NS = 20;
	localparam int LINK_PERIOD_NS = 80;
	localparam int K_DIV = LINK_PERIOD_NS / CLK_PERIOD_NS;

	// Divider phases: the link clock is the top bit of the phase.
	localparam int K_BIT = 1;
	localparam phase_t PH_CMD = 2'h0;
	localparam phase_t PH_HALF = 2'h2;
	localparam phase_t PH_BEAT0 = 2'h3;
	localparam phase_t PH_BEAT1 = 2'h1;
	localparam phase_t PH_STEP = 2'h1;

	// Read return capture states.
	typedef enum logic [1:0] {
		CAP_FIRST  = 2'b01,
		CAP_SECOND = 2'b10
	} cap_state_t;

endpackage

// >>> src/qdr_b2_link_if.sv
// Pin-level link between the memory controller and the static memory.
// Assumes the controller makes the link clock; the inverted clock is implied.
`timescale 1ns/100ps
interface qdr_b2_link_if;

	logic                 input_clock;
	logic                 write_cmd_n;
	logic                 read_cmd_n;
	qdr_b2_pkg::addr_t    sync_address_in;
	qdr_b2_pkg::word_t    write_data_in;
	qdr_b2_pkg::mask_t    byte_write_mask_n;
	qdr_b2_pkg::word_t    read_data_out;
	logic                 read_data_valid;
	logic                 echo_clock_true;
	logic                 echo_clock_inverted;

	modport device (
		input  input_clock,
		input  write_cmd_n,
		input  read_cmd_n,
		input  sync_address_in,
		input  write_data_in,
		input  byte_write_mask_n,
		output read_data_out,
		output read_data_valid,
		output echo_clock_true,
		output echo_clock_inverted
	);

	modport controller (
		output input_clock,
		output write_cmd_n,
		output read_cmd_n,
		output sync_address_in,
		output write_data_in,
		output byte_write_mask_n,
		input  read_data_out,
		input  read_data_valid,
		input  echo_clock_true,
		input  echo_clock_inverted
	);

endinterface

// >>> src/qdr_b2_device.sv
// Burst-of-two DDR static memory: separate read and write ports.
// Assumes the link clock runs whenever reset or commands are given.
`timescale 1ns/100ps

// How it works
// - Separate read and write ports run concurrently.
// - Every transfer moves exactly two beats.
// - Commands sampled on rising clock edges only.
// - Address bus carries two addresses per cycle.
// - Read data starts two and a half cycles after command, loop on.
// - Per-beat byte masks, each byte separately.
// - Write buffer holds data before its address.
// - Controller gives beats on clock, then inverted.
// - First read beat on inverted clock edge.
// - Second read beat on third true edge, loop on.
// - Echo clocks aligned with read data.
// - Valid output marks read data beats.
// - Organisation is 2Mx36 or 4Mx18 build choice.
// - Low write command starts a write.
// - Low read command starts a read.
// - Byte written only when its mask low.
// - Loop bypass gives one cycle less latency.
module qdr_b2_device (
	// Link to the memory controller.
	qdr_b2_link_if.device link,
	// Reset and mode pins.
	input  wire logic     i_rst,
	input  wire logic     i_dll_enable
);

	////////////////////////////////////////////////////////////////////////
	// Byte merge of a write beat into a stored word.

	function automatic qdr_b2_pkg::word_t merge_bytes(
		input qdr_b2_pkg::word_t old_word,
		input qdr_b2_pkg::word_t new_word,
		input qdr_b2_pkg::mask_t mask_n
	);
		qdr_b2_pkg::word_t res;
		res = old_word;
		for (int b = 0; b < qdr_b2_pkg::BYTES; b++) begin
			if (!mask_n[b]) begin
				res[b*qdr_b2_pkg::BYTE_W +: qdr_b2_pkg::BYTE_W] =
					new_word[b*qdr_b2_pkg::BYTE_W +: qdr_b2_pkg::BYTE_W];
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Storage, sized by the organisation choice.

	qdr_b2_pkg::word_t    mem [0:qdr_b2_pkg::MEM_WORDS-1];

	// Synchronised pins.
	logic                 rst_meta;
	logic                 rst_sync;
	logic                 dll_meta;
	logic                 dll_sync;

	// True-edge command capture.
	logic                 rd_pend;
	qdr_b2_pkg::addr_t    rd_addr;
	logic                 wr_pend;
	qdr_b2_pkg::word_t    wr_beat0;
	qdr_b2_pkg::mask_t    wr_mask0;

	// Fetched read bursts, two stages on the inverted edge.
	logic                 fa_valid;
	qdr_b2_pkg::word_t    fa_word0;
	qdr_b2_pkg::word_t    fa_word1;
	logic                 fb_valid;
	qdr_b2_pkg::word_t    fb_word0;
	qdr_b2_pkg::word_t    fb_word1;

	// Output registers for each clock half.
	qdr_b2_pkg::word_t    q_neg;
	logic                 v_neg;
	qdr_b2_pkg::word_t    q_pos;
	logic                 v_pos;
	qdr_b2_pkg::word_t    hold_word1;
	logic                 beat1_pend;
	logic                 echo_pos;
	logic                 echo_neg;

	////////////////////////////////////////////////////////////////////////
	// Decoding and selection.
	// A read meeting a write to its own address takes the merged words.

	wire                  rd_cmd = !link.read_cmd_n;
	wire                  wr_cmd = !link.write_cmd_n;
	wire qdr_b2_pkg::addr_t wr_addr = link.sync_address_in;
	wire qdr_b2_pkg::word_t merged0 = merge_bytes(
		mem[{wr_addr, qdr_b2_pkg::BEAT_FIRST}], wr_beat0, wr_mask0);
	wire qdr_b2_pkg::word_t merged1 = merge_bytes(
		mem[{wr_addr, qdr_b2_pkg::BEAT_SECOND}], link.write_data_in,
		link.byte_write_mask_n);
	wire                  wr_hit = wr_pend && (wr_addr == rd_addr);
	wire qdr_b2_pkg::word_t fetch0 = wr_hit ? merged0 :
		mem[{rd_addr, qdr_b2_pkg::BEAT_FIRST}];
	wire qdr_b2_pkg::word_t fetch1 = wr_hit ? merged1 :
		mem[{rd_addr, qdr_b2_pkg::BEAT_SECOND}];
	wire                  send = dll_sync ? fb_valid : fa_valid;
	wire qdr_b2_pkg::word_t send0 = dll_sync ? fb_word0 : fa_word0;
	wire qdr_b2_pkg::word_t send1 = dll_sync ? fb_word1 : fa_word1;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers on the true edge.
	// Reset and loop mode come from outside and pass two flops first.

	always_ff @(posedge link.input_clock) begin
		rst_meta <= i_rst;
		rst_sync <= rst_meta;
		dll_meta <= i_dll_enable;
		dll_sync <= dll_meta;
	end

	////////////////////////////////////////////////////////////////////////
	// True edge: commands, read address and first write beat.

	always_ff @(posedge link.input_clock) begin
		if (rst_sync) begin
			rd_pend <= 1'b0;
			wr_pend <= 1'b0;
		end else begin
			rd_pend <= rd_cmd;
			wr_pend <= wr_cmd;
		end
		if (rd_cmd) begin
			rd_addr <= link.sync_address_in;
		end
		if (wr_cmd) begin
			wr_beat0 <= link.write_data_in;
			wr_mask0 <= link.byte_write_mask_n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Inverted edge: write address, second beat and commit of both beats.
	// The commit waits for the address, half a cycle after the first beat.

	always_ff @(negedge link.input_clock) begin
		if (wr_pend && !rst_sync) begin
			mem[{wr_addr, qdr_b2_pkg::BEAT_FIRST}] <= merged0;
			mem[{wr_addr, qdr_b2_pkg::BEAT_SECOND}] <= merged1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Inverted edge: read fetch pipeline and first output beat.

	always_ff @(negedge link.input_clock) begin
		if (rst_sync) begin
			fa_valid <= 1'b0;
			fb_valid <= 1'b0;
			v_neg <= 1'b0;
			beat1_pend <= 1'b0;
			q_neg <= '0;
			echo_neg <= 1'b0;
		end else begin
			fa_valid <= rd_pend;
			fb_valid <= fa_valid;
			v_neg <= send;
			beat1_pend <= send;
			echo_neg <= 1'b0;
			if (send) begin
				q_neg <= send0;
			end
		end
		fa_word0 <= fetch0;
		fa_word1 <= fetch1;
		fb_word0 <= fa_word0;
		fb_word1 <= fa_word1;
		hold_word1 <= send1;
	end

	////////////////////////////////////////////////////////////////////////
	// True edge: second output beat and echo level.

	always_ff @(posedge link.input_clock) begin
		if (rst_sync) begin
			v_pos <= 1'b0;
			q_pos <= '0;
			echo_pos <= 1'b0;
		end else begin
			v_pos <= beat1_pend;
			echo_pos <= 1'b1;
			if (beat1_pend) begin
				q_pos <= hold_word1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Double-rate output selection by clock half.
	// The high half shows the true-edge registers, the low half the others.
	// Each beat thus stands for one half period, and the echo clocks
	// change with the data, so the far end can use them as its strobe.

	wire                  k_high = link.input_clock;

	assign link.read_data_out = k_high ? q_pos : q_neg;
	assign link.read_data_valid = k_high ? v_pos : v_neg;
	assign link.echo_clock_true = k_high ? echo_pos : echo_neg;
	assign link.echo_clock_inverted =
		k_high ? echo_neg : echo_pos;

endmodule // qdr_b2_device

// >>> src/qdr_b2_controller.sv
// Memory controller end: makes the link clock and issues bursts.
// Assumes requests and reset come from logic on i_clk.
`timescale 1ns/100ps
module qdr_b2_controller (
	// Link to the static memory.
	qdr_b2_link_if.controller link,
	// Clock and reset.
	input  wire logic                i_clk,
	input  wire logic                i_rst,
	// Write requests.
	input  wire logic                i_wr_req,
	input  wire qdr_b2_pkg::addr_t   i_wr_addr,
	input  wire qdr_b2_pkg::word_t   i_wr_data0,
	input  wire qdr_b2_pkg::word_t   i_wr_data1,
	input  wire qdr_b2_pkg::mask_t   i_wr_mask0_n,
	input  wire qdr_b2_pkg::mask_t   i_wr_mask1_n,
	// Read requests.
	input  wire logic                i_rd_req,
	input  wire qdr_b2_pkg::addr_t   i_rd_addr,
	// Request acceptance.
	output logic                     o_req_ready,
	// Read return.
	output qdr_b2_pkg::word_t        o_rd_data0,
	output qdr_b2_pkg::word_t        o_rd_data1,
	output logic                     o_rd_valid
);

	qdr_b2_pkg::phase_t      phase;
	logic                    w_n;
	logic                    r_n;
	qdr_b2_pkg::addr_t       addr;
	qdr_b2_pkg::word_t       wdata;
	qdr_b2_pkg::mask_t       wmask;
	logic                    w_hold;
	qdr_b2_pkg::addr_t       wa_hold;
	qdr_b2_pkg::word_t       wd1_hold;
	qdr_b2_pkg::mask_t       wm1_hold;
	qdr_b2_pkg::word_t       q_meta;
	qdr_b2_pkg::word_t       q_sync;
	logic                    v_meta;
	logic                    v_sync;
	qdr_b2_pkg::cap_state_t  cap;

	wire qdr_b2_pkg::phase_t next_phase = phase + qdr_b2_pkg::PH_STEP;
	wire                     at_cmd = (phase == qdr_b2_pkg::PH_CMD);
	wire                     at_half = (phase == qdr_b2_pkg::PH_HALF);
	wire                     wr_take = i_wr_req && o_req_ready && at_cmd;
	wire                     rd_take = i_rd_req && o_req_ready && at_cmd;

	////////////////////////////////////////////////////////////////////////
	// Link clock divider and pin drive.

	assign link.input_clock = phase[qdr_b2_pkg::K_BIT];
	assign link.write_cmd_n = w_n;
	assign link.read_cmd_n = r_n;
	assign link.sync_address_in = addr;
	assign link.write_data_in = wdata;
	assign link.byte_write_mask_n = wmask;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			phase <= qdr_b2_pkg::PH_CMD;
			o_req_ready <= 1'b0;
		end else begin
			phase <= next_phase;
			o_req_ready <= (next_phase == qdr_b2_pkg::PH_CMD);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command, address and data beats.

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			w_n <= 1'b1;
			r_n <= 1'b1;
			addr <= '0;
			wdata <= '0;
			wmask <= qdr_b2_pkg::MASK_NONE;
			w_hold <= 1'b0;
		end else if (at_cmd) begin
			w_n <= !wr_take;
			r_n <= !rd_take;
			w_hold <= wr_take;
			addr <= i_rd_addr;
			wdata <= i_wr_data0;
			wmask <= wr_take ? i_wr_mask0_n : qdr_b2_pkg::MASK_NONE;
		end else if (at_half) begin
			addr <= wa_hold;
			wdata <= wd1_hold;
			wmask <= w_hold ? wm1_hold : qdr_b2_pkg::MASK_NONE;
		end
	end

	always_ff @(posedge i_clk) begin
		if (wr_take) begin
			wa_hold <= i_wr_addr;
			wd1_hold <= i_wr_data1;
			wm1_hold <= i_wr_mask1_n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read return: synchronise, then pair the two beats.

	always_ff @(posedge i_clk) begin
		q_meta <= link.read_data_out;
		q_sync <= q_meta;
		v_meta <= link.read_data_valid;
		v_sync <= v_meta;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cap <= qdr_b2_pkg::CAP_FIRST;
			o_rd_valid <= 1'b0;
			o_rd_data0 <= '0;
			o_rd_data1 <= '0;
		end else begin
			o_rd_valid <= 1'b0;
			case (cap)
				qdr_b2_pkg::CAP_FIRST: begin
					if (v_sync && phase == qdr_b2_pkg::PH_BEAT0) begin
						o_rd_data0 <= q_sync;
						cap <= qdr_b2_pkg::CAP_SECOND;
					end
				end
				qdr_b2_pkg::CAP_SECOND: begin
					if (phase == qdr_b2_pkg::PH_BEAT1) begin
						o_rd_data1 <= q_sync;
						o_rd_valid <= v_sync;
						cap <= qdr_b2_pkg::CAP_FIRST;
					end
				end
				default: begin
					cap <= qdr_b2_pkg::CAP_FIRST;
				end
			endcase
		end
	end

endmodule // qdr_b2_controller

// >>> bench/qdr_b2_assertions.sv
// Link checker: read return timing, echo clocks and quiet reset.
// Assumes it sits beside the link interface and sees its signals.
`timescale 1ns/100ps
module qdr_b2_checker (
	// Link clock and commands.
	input  wire logic input_clock,
	input  wire logic write_cmd_n,
	input  wire logic read_cmd_n,
	// Read return.
	input  wire logic read_data_valid,
	input  wire logic echo_clock_true,
	input  wire logic echo_clock_inverted,
	// Device reset and loop mode.
	input  wire logic i_rst,
	input  wire logic i_dll_enable
);
	logic [2:0] rst_cnt;
	logic [2:0] dll_cnt;
	logic       dll_seen;
	logic       ok_on;
	logic       ok_off;

	////////////////////////////////////////////////////////////////////////
	// Counts of link rises since reset release and since a mode change.
	always_ff @(posedge input_clock) begin
		dll_seen <= i_dll_enable;
		rst_cnt <= i_rst ? 3'h0 : rst_cnt + {2'h0, rst_cnt != 3'h7};
		dll_cnt <= (i_rst || dll_seen != i_dll_enable) ? 3'h0
			: dll_cnt + {2'h0, dll_cnt != 3'h7};
	end
	assign ok_on  = rst_cnt == 3'h7 && dll_cnt == 3'h7 && i_dll_enable;
	assign ok_off = rst_cnt == 3'h7 && dll_cnt == 3'h7 && !i_dll_enable;

	////////////////////////////////////////////////////////////////////////
	// Read beats and their valid flag.
	beat0_on_a: assert property (@(posedge input_clock)
		disable iff (i_rst) ok_on |->
		read_data_valid == !$past(read_cmd_n, 3))
		else $error("First read beat misplaced.");
	beat1_on_a: assert property (@(negedge input_clock)
		disable iff (i_rst) ok_on |->
		read_data_valid == !$past(read_cmd_n, 3))
		else $error("Second read beat misplaced.");
	beat0_off_a: assert property (@(posedge input_clock)
		disable iff (i_rst) ok_off |->
		read_data_valid == !$past(read_cmd_n, 2))
		else $error("First bypass beat misplaced.");
	beat1_off_a: assert property (@(negedge input_clock)
		disable iff (i_rst) ok_off |->
		read_data_valid == !$past(read_cmd_n, 2))
		else $error("Second bypass beat misplaced.");

	////////////////////////////////////////////////////////////////////////
	// Echo clocks and reset.
	echo_rise_a: assert property (@(posedge input_clock)
		disable iff (i_rst) rst_cnt == 3'h7 |->
		echo_clock_inverted && !echo_clock_true)
		else $error("Echo clocks wrong before a rise.");
	echo_fall_a: assert property (@(negedge input_clock)
		disable iff (i_rst) rst_cnt == 3'h7 |->
		echo_clock_true && !echo_clock_inverted)
		else $error("Echo clocks wrong before a fall.");
	rst_quiet_a: assert property (@(posedge input_clock)
		i_rst && $past(i_rst) && $past(i_rst, 2) |=>
		!read_data_valid && !echo_clock_true && !echo_clock_inverted)
		else $error("Outputs active in reset.");
	rst_quiet_fall_a: assert property (@(negedge input_clock)
		i_rst && $past(i_rst) && $past(i_rst, 2) |->
		!read_data_valid[*2])
		else $error("Valid active in reset.");

	cover property (@(posedge input_clock) ok_on && !read_cmd_n);
	cover property (@(posedge input_clock) ok_off && !read_cmd_n);
	cover property (@(posedge input_clock) !write_cmd_n && !read_cmd_n);
endmodule // qdr_b2_checker

// >>> bench/tb_quad_port_ddr_burst2_sram_interface.sv
// Bench: controller and static memory joined by the link interface.
// Assumes the package selects the 36-bit organisation.
`timescale 1ns/100ps
module tb_quad_port_ddr_burst2_sram_interface;
	typedef qdr_b2_pkg::word_t w_t;
	typedef struct {
		logic              wr;
		logic              rd;
		qdr_b2_pkg::addr_t wa;
		qdr_b2_pkg::addr_t ra;
		w_t                d0;
		w_t                d1;
		qdr_b2_pkg::mask_t m0;
		qdr_b2_pkg::mask_t m1;
		w_t                e0;
		w_t                e1;
	} row_t;

	row_t rows [6];
	row_t drv;
	w_t   exq [$];
	int   n_mismatch;
	int   checked;
	logic i_clk;
	logic i_rst;
	logic dev_rst;
	logic dll_en;
	logic req_ready;
	logic rd_valid;
	w_t   rd_data0;
	w_t   rd_data1;

	qdr_b2_link_if link ();
	qdr_b2_controller qdr_b2_controller_inst (
		.link         (link),
		.i_clk        (i_clk),
		.i_rst        (i_rst),
		.i_wr_req     (drv.wr),
		.i_wr_addr    (drv.wa),
		.i_wr_data0   (drv.d0),
		.i_wr_data1   (drv.d1),
		.i_wr_mask0_n (drv.m0),
		.i_wr_mask1_n (drv.m1),
		.i_rd_req     (drv.rd),
		.i_rd_addr    (drv.ra),
		.o_req_ready  (req_ready),
		.o_rd_data0   (rd_data0),
		.o_rd_data1   (rd_data1),
		.o_rd_valid   (rd_valid)
	);
	qdr_b2_device qdr_b2_device_inst (
		.link         (link),
		.i_rst        (dev_rst),
		.i_dll_enable (dll_en)
	);
	qdr_b2_checker qdr_b2_checker_inst (
		.input_clock         (link.input_clock),
		.write_cmd_n         (link.write_cmd_n),
		.read_cmd_n          (link.read_cmd_n),
		.read_data_valid     (link.read_data_valid),
		.echo_clock_true     (link.echo_clock_true),
		.echo_clock_inverted (link.echo_clock_inverted),
		.i_rst               (dev_rst),
		.i_dll_enable        (dll_en)
	);

	////////////////////////////////////////////////////////////////////////
	// Comparison, verdict and bus tasks.
	task automatic check(input w_t seen, input w_t exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (n_mismatch == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic hang(input int n);
		if (n >= 100) begin
			n_mismatch++;
			$display("[ERR] %0t wait ran out", $time);
			results();
		end
	endtask

	task automatic issue(input row_t r);
		int n;
		drv <= r;
		@(posedge i_clk);
		for (n = 0; n < 100 && req_ready !== 1'h1; n++)
			@(posedge i_clk);
		hang(n);
		drv.wr <= 1'h0;
		drv.rd <= 1'h0;
		if (r.rd) begin
			exq.push_back(r.e0);
			exq.push_back(r.e1);
		end
	endtask

	task automatic drain();
		int n;
		@(posedge i_clk);
		drv.wr <= 1'h0;
		drv.rd <= 1'h0;
		for (n = 0; n < 100 && exq.size() != 0; n++)
			@(posedge i_clk);
		hang(n);
		repeat (8) @(posedge i_clk);
	endtask

	task automatic wire_check(input row_t r);
		@(posedge link.input_clock);
		check(w_t'(link.read_cmd_n), w_t'(!r.rd));
		check(w_t'(link.write_cmd_n), w_t'(!r.wr));
		if (r.rd)
			check(w_t'(link.sync_address_in), w_t'(r.ra));
		if (r.wr)
			check(link.write_data_in, r.d0);
		if (r.wr)
			check(w_t'(link.byte_write_mask_n), w_t'(r.m0));
		@(negedge link.input_clock);
		if (r.wr)
			check(link.write_data_in, r.d1);
		if (r.wr)
			check(w_t'(link.byte_write_mask_n), w_t'(r.m1));
		if (r.wr)
			check(w_t'(link.sync_address_in), w_t'(r.wa));
	endtask

	////////////////////////////////////////////////////////////////////////
	// Clock and read return monitor.
	initial begin
		i_clk = 1'h0;
		forever #10 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		if (rd_valid === 1'h1) begin
			if (exq.size() < 2)
				check(w_t'(rd_valid), 36'h0);
			else
				check(rd_data0, exq.pop_front());
			if (exq.size() != 0)
				check(rd_data1, exq.pop_front());
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		n_mismatch = 0;
		checked = 0;
		drv = '{default: '0};
		i_rst = 1'h1;
		dev_rst = 1'h1;
		dll_en = 1'h1;
		rows = '{
			'{1'h1, 1'h0, 20'hfffff, 20'h0, 36'h111111111, 36'h222222222,
				4'h0, 4'h0, 36'h0, 36'h0},
			'{1'h1, 1'h1, 20'h0, 20'hfffff, 36'h0, 36'h0,
				4'h0, 4'h0, 36'h111111111, 36'h222222222},
			'{1'h1, 1'h1, 20'h0, 20'h0, 36'hfffffffff, 36'hfffffffff,
				4'h5, 4'ha, 36'hff803fe00, 36'h007fc01ff},
			'{1'h0, 1'h0, 20'h0, 20'h0, 36'h0, 36'h0,
				4'hf, 4'hf, 36'h0, 36'h0},
			'{1'h1, 1'h1, 20'hfffff, 20'h0, 36'hfffffffff, 36'hfffffffff,
				4'hf, 4'hf, 36'hff803fe00, 36'h007fc01ff},
			'{1'h0, 1'h1, 20'h0, 20'hfffff, 36'h0, 36'h0,
				4'hf, 4'hf, 36'h111111111, 36'h222222222}};
		repeat (16) @(posedge i_clk);
		check(w_t'(req_ready), 36'h0);
		check(w_t'(link.input_clock), 36'h0);
		check(w_t'(link.read_cmd_n), 36'h1);
		i_rst <= 1'h0;
		repeat (16) @(posedge i_clk);
		dev_rst <= 1'h0;
		repeat (16) @(posedge i_clk);
		foreach (rows[i]) begin
			issue(rows[i]);
			wire_check(rows[i]);
		end
		drain();
		dll_en <= 1'h0;
		repeat (48) @(posedge i_clk);
		issue(rows[2]);
		drain();
		dll_en <= 1'h1;
		repeat (48) @(posedge i_clk);
		dev_rst <= 1'h1;
		repeat (16) @(posedge i_clk);
		check(w_t'(link.echo_clock_true), 36'h0);
		check(w_t'(link.read_data_valid), 36'h0);
		dev_rst <= 1'h0;
		repeat (16) @(posedge i_clk);
		issue(rows[0]);
		wire_check(rows[0]);
		issue(rows[5]);
		wire_check(rows[5]);
		drain();
		results();
	end
endmodule // tb_quad_port_ddr_burst2_sram_interface
